// File: sbc_readout_pkg.sv
/*
 * constants, field positions and carrier types for the flag and status read-back block.
 * assumes a 16-bit serial read word with the bank address in bits 13..9.
 */
package sbc_readout_pkg;
	localparam int FRAME_BITS = 16;
	localparam logic [1:0] TYPE_FLAGS = 2'b11;
	localparam logic [1:0] TYPE_LIVE = 2'b00;
	localparam logic [4:0] BANK_CAN = 5'h10;
	localparam logic [4:0] BANK_IO = 5'h11;
	localparam logic [4:0] BANK_SAFE = 5'h12;
	localparam logic [4:0] BANK_LIN = 5'h13;
	localparam logic [7:0] FIXED_STATUS = 8'h00;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// bits that exist in each latched byte; the rest always read zero
	localparam logic [7:0] MASK_CAN_LO = 8'hbf;
	localparam logic [7:0] MASK_CAN_HI = 8'hff;
	localparam logic [7:0] MASK_IO_LO = 8'hff;
	localparam logic [7:0] MASK_IO_HI = 8'hff;
	localparam logic [7:0] MASK_SAFE_LO = 8'hfe;
	localparam logic [7:0] MASK_SAFE_HI = 8'h1f;
	localparam logic [7:0] MASK_LIN_LO = 8'h7f;
	localparam int ID_VARIANT_BIT = 7;
	localparam int ID_PN_LSB = 5;
	localparam int ID_FIELD_LSB = 0;

	typedef struct packed {
		logic [7:0] can_lo;
		logic [7:0] can_hi;
		logic [7:0] io_lo;
		logic [7:0] io_hi;
		logic [7:0] safe_lo;
		logic [7:0] safe_hi;
		logic [7:0] lin_lo;
	} flag_bytes_t;

	typedef struct packed {
		logic [7:0] can;
		logic [7:0] io;
		logic [7:0] ident;
		logic [7:0] lin;
	} live_bytes_t;

	typedef struct packed {
		logic can_driver_on;
		logic can_receiver_on;
		logic can_wake_enable_state;
		logic [3:0] io_level;
		logic lin_transceiver_state;
		logic lin_wake_enable_state;
		logic vdd_is_5v;
	} live_in_t;
endpackage : sbc_readout_pkg

// File: sbc_sync3.sv
/*
 * three-stage synchroniser, one generate lane per bit.
 * a new level is accepted only once the second and third stages agree.
 */
`timescale 1ns/1ps
`default_nettype none
module sbc_sync3 #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_lane
			typedef struct packed {
				logic s1;
				logic s2;
				logic s3;
				logic q;
			} lane_t;
			lane_t st;
			lane_t next_st;
			always_comb
			begin
				next_st = st;
				next_st.s1 = async_in[i];
				next_st.s2 = st.s1;
				next_st.s3 = st.s2;
				if (st.s2 == st.s3)
				begin
					next_st.q = st.s3;
				end
			end
			always_ff @(posedge clk)
			begin
				if (srst)
				begin
					st <= '0;
				end
				else
				begin
					st <= next_st;
				end
			end
			assign sync_out[i] = st.q;
		end
	endgenerate
endmodule : sbc_sync3
`default_nettype wire

// File: sbc_flag_status_readout.sv
/*
 * latched fault flags and live status bytes of four banks, read back over a 16-bit serial frame.
 * assumes the host waits at least 25 ns after chip select falls before its first serial edge,
 * and that events and live levels arrive as asynchronous levels from the analog detectors.
 */
// Summary of operation
// - a flag read of bank 1_0000 with bit 7 low returns the CAN wake, overtemp, receive, transmit, clamp and overcurrent flags.
// - a flag read of bank 1_0000 with bit 7 high returns the CAN line fault byte with both combined failure bits on top.
// - a live read of bank 1_0011 returns the LIN transceiver state in bit 7 and its wake enable in bit 6, other bits zero.
// - the live byte of the safety bank holds the regulator variant in bit 7, part code in bits 6..5 and identity in bits 4..0.
// - each flag latches on its event and clears only on a flag read once its condition has gone.
// - live bits follow the present condition and no read alters them.
`timescale 1ns/1ps
`default_nettype none
module sbc_flag_status_readout
	import sbc_readout_pkg::*;
#(
	parameter logic [1:0] PART_CODE = 2'h0, // arbitrary value
	parameter logic [4:0] IDENT_CODE = 5'h00 // arbitrary value
) (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic SPI_SCLK,
	input wire logic CHIP_SELECT_PIN_N,
	input wire logic SPI_MOSI,
	output logic SPI_MISO,
	output logic SPI_MISO_OE,
	input wire flag_bytes_t FAULT_EVENT,
	input wire live_in_t LIVE_IN
);
	typedef struct packed {
		logic [4:0] cnt;
		logic [15:0] shift;
		logic [7:0] hdr;
		logic sel;
		logic [7:0] rbyte;
		logic rflag;
	} spi_state_t;

	typedef struct packed {
		flag_bytes_t flags;
		flag_bytes_t snap_flags;
		live_bytes_t snap_live;
		logic done_q;
	} core_state_t;

	localparam flag_bytes_t FLAG_MASK = '{MASK_CAN_LO, MASK_CAN_HI, MASK_IO_LO, MASK_IO_HI,
		MASK_SAFE_LO, MASK_SAFE_HI, MASK_LIN_LO};

	spi_state_t sst;
	spi_state_t next_sst;
	core_state_t cst;
	core_state_t next_cst;
	flag_bytes_t ev_sync;
	live_in_t live_sync;
	logic [1:0] frame_sync;
	logic done;
	live_bytes_t live_now;

	// selects the byte a command asks for from the frozen image
	function automatic logic [7:0] pick(input logic [7:0] h, input logic s, input flag_bytes_t f,
		input live_bytes_t l);
		logic [7:0] b;
		b = RESET_BYTE;
		if (h[0] && h[7:6] == TYPE_FLAGS)
		begin
			case (h[5:1])
				BANK_CAN: b = s ? f.can_hi : f.can_lo;
				BANK_IO: b = s ? f.io_hi : f.io_lo;
				BANK_SAFE: b = s ? f.safe_hi : f.safe_lo;
				BANK_LIN: b = s ? RESET_BYTE : f.lin_lo;
				default: b = RESET_BYTE;
			endcase
		end
		else if (h[0] && h[7:6] == TYPE_LIVE)
		begin
			case (h[5:1])
				BANK_CAN: b = l.can;
				BANK_IO: b = l.io;
				BANK_SAFE: b = l.ident;
				BANK_LIN: b = l.lin;
				default: b = RESET_BYTE;
			endcase
		end
		return b;
	endfunction : pick

	sbc_sync3 #(.WIDTH($bits(flag_bytes_t))) u_sync_ev (
		.clk(CLK),
		.srst(SRST),
		.async_in(FAULT_EVENT),
		.sync_out(ev_sync)
	);

	sbc_sync3 #(.WIDTH($bits(live_in_t))) u_sync_live (
		.clk(CLK),
		.srst(SRST),
		.async_in(LIVE_IN),
		.sync_out(live_sync)
	);

	sbc_sync3 #(.WIDTH(2)) u_sync_frame (
		.clk(CLK),
		.srst(SRST),
		.async_in({CHIP_SELECT_PIN_N, sst.rflag}),
		.sync_out(frame_sync)
	);

	// serial side: cleared by chip select, so nothing depends on edges outside a frame
	always_comb
	begin
		next_sst = sst;
		if (sst.cnt < 5'(FRAME_BITS))
		begin
			next_sst.shift = {sst.shift[14:0], SPI_MOSI};
			next_sst.cnt = sst.cnt + 5'd1;
		end
		else if (sst.cnt == 5'(FRAME_BITS))
		begin
			// overlong frame withdraws the clear request
			next_sst.cnt = sst.cnt + 5'd1;
			next_sst.rflag = 1'b0;
		end
		if (sst.cnt == 5'd8)
		begin
			next_sst.hdr = sst.shift[7:0];
			next_sst.sel = SPI_MOSI;
		end
		if (sst.cnt == 5'(FRAME_BITS - 1))
		begin
			next_sst.rbyte = pick(sst.hdr, sst.sel, cst.snap_flags, cst.snap_live);
			next_sst.rflag = sst.hdr[0] && sst.hdr[7:6] == TYPE_FLAGS;
		end
	end

	always_ff @(posedge SPI_SCLK or posedge CHIP_SELECT_PIN_N)
	begin
		if (CHIP_SELECT_PIN_N)
		begin
			sst <= '0;
		end
		else
		begin
			sst <= next_sst;
		end
	end

	assign done = frame_sync[0];

	always_comb
	begin
		live_now.can = {live_sync.can_driver_on, live_sync.can_receiver_on, live_sync.can_wake_enable_state,
			5'h00};
		live_now.io = {1'b0, live_sync.io_level[3], 1'b0, live_sync.io_level[2], 1'b0, live_sync.io_level[1],
			1'b0, live_sync.io_level[0]};
		live_now.ident = RESET_BYTE;
		live_now.ident[ID_VARIANT_BIT] = live_sync.vdd_is_5v;
		live_now.ident[ID_PN_LSB +: 2] = PART_CODE;
		live_now.ident[ID_FIELD_LSB +: 5] = IDENT_CODE;
		live_now.lin = {live_sync.lin_transceiver_state, live_sync.lin_wake_enable_state, 6'h00};
	end

	// core side: flags latch, image freezes while a frame is open
	always_comb
	begin
		logic [7:0] clr;
		flag_bytes_t clr_mask;
		clr = RESET_BYTE;
		clr_mask = '0;
		next_cst = cst;
		next_cst.done_q = done;
		if (done && !cst.done_q)
		begin
			clr = sst.rbyte;
			case (sst.hdr[5:1])
				BANK_CAN:
				begin
					if (sst.sel)
					begin
						clr_mask.can_hi = clr;
					end
					else
					begin
						clr_mask.can_lo = clr;
					end
				end
				BANK_IO:
				begin
					if (sst.sel)
					begin
						clr_mask.io_hi = clr;
					end
					else
					begin
						clr_mask.io_lo = clr;
					end
				end
				BANK_SAFE:
				begin
					if (sst.sel)
					begin
						clr_mask.safe_hi = clr;
					end
					else
					begin
						clr_mask.safe_lo = clr;
					end
				end
				BANK_LIN:
				begin
					clr_mask.lin_lo = sst.sel ? RESET_BYTE : clr;
				end
				default:
				begin
					clr_mask = '0;
				end
			endcase
		end
		// only bits that were read as set are cleared; a live event keeps its flag
		next_cst.flags = ((cst.flags & ~clr_mask) | ev_sync) & FLAG_MASK;
		if (frame_sync[1])
		begin
			next_cst.snap_flags = cst.flags;
			next_cst.snap_live = live_now;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			cst <= '0;
		end
		else
		begin
			cst <= next_cst;
		end
	end

	// bit 7 is answered from the pin itself because the host sends it in the same slot
	always_comb
	begin
		logic [7:0] b;
		b = RESET_BYTE;
		SPI_MISO = 1'b0;
		if (sst.cnt < 5'd8)
		begin
			SPI_MISO = FIXED_STATUS[3'(7 - sst.cnt)];
		end
		else if (sst.cnt == 5'd8)
		begin
			b = pick(sst.shift[7:0], SPI_MOSI, cst.snap_flags, cst.snap_live);
			SPI_MISO = b[7];
		end
		else if (sst.cnt < 5'(FRAME_BITS))
		begin
			b = pick(sst.hdr, sst.sel, cst.snap_flags, cst.snap_live);
			SPI_MISO = b[3'(FRAME_BITS - 1 - sst.cnt)];
		end
		SPI_MISO_OE = !CHIP_SELECT_PIN_N;
	end
endmodule : sbc_flag_status_readout
`default_nettype wire

// File: sbc_host_model.sv
/* host serial master that frames read commands.
 assumes the block samples on the rising serial edge. */
`timescale 1ns/1ps
`default_nettype none
module sbc_host_model (
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	task automatic frame(input logic [15:0] cmd, input int n, output logic [15:0] r);
		cs_n = 1'b0;
		#30;
		for (int i = 0; i < n; i++)
		begin
			mosi = cmd[15 - i % 16];
			#7.5;
			if (i < 16)
				r = {r[14:0], miso};
			sclk = 1'b1;
			#7.5;
			sclk = 1'b0;
		end
		// hold select until the core has taken the clear request of a flag read
		#40;
		cs_n = 1'b1;
		mosi = !mosi;
		#40;
	endtask : frame
endmodule : sbc_host_model
`default_nettype wire

// File: sbc_flag_status_readout_chk.sv
/* assertions at the ports of the read-back block.
 assumes 16-bit frames with the header in the first eight serial bits. */
`timescale 1ns/1ps
`default_nettype none
module sbc_flag_status_readout_chk (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic SPI_SCLK,
	input wire logic CHIP_SELECT_PIN_N,
	input wire logic SPI_MOSI,
	input wire logic SPI_MISO,
	input wire logic SPI_MISO_OE
);
	logic [4:0] cnt;
	logic [7:0] hdr;
	logic body;
	assign body = cnt[4:3] == 2'b01;
	// serial edges and header bits of the current frame
	always_ff @(posedge SPI_SCLK or posedge CHIP_SELECT_PIN_N)
	begin
		if (CHIP_SELECT_PIN_N)
		begin
			cnt <= 5'h00;
			hdr <= 8'h00;
		end
		else
		begin
			cnt <= cnt + {4'h0, cnt < 5'h11};
			hdr <= cnt < 5'h08 ? {hdr[6:0], SPI_MOSI} : hdr;
		end
	end
	// the fixed status byte: eight serial slots at zero
	sequence s_status_zero;
		(!SPI_MISO) [*8];
	endsequence
	property p_zero(c);
		@(posedge SPI_SCLK) disable iff (CHIP_SELECT_PIN_N) c |-> !SPI_MISO;
	endproperty
	a_idle_miso_low: assert property (@(posedge CLK) disable iff (SRST) CHIP_SELECT_PIN_N |-> !SPI_MISO)
		else $error("miso not low when idle");
	a_oe_tracks_cs: assert property (@(posedge CLK) disable iff (SRST) SPI_MISO_OE == !CHIP_SELECT_PIN_N)
		else $error("oe not following select");
	a_header_zero: assert property (@(posedge SPI_SCLK) disable iff (CHIP_SELECT_PIN_N)
		cnt == 5'h00 |-> s_status_zero) else $error("status byte not zero");
	a_tail_zero: assert property (p_zero(cnt > 5'h0f))
		else $error("bit after frame end");
	a_refused_zero: assert property (p_zero(body && (hdr[7] != hdr[6] || !hdr[0])))
		else $error("refused read gave data");
	a_lin_live_unused: assert property (p_zero(body && hdr == 8'h27 && cnt > 5'h09))
		else $error("lin unused bit set");
	a_can_live_unused: assert property (p_zero(body && hdr == 8'h21 && cnt > 5'h0a))
		else $error("can unused bit set");
	a_io_live_gaps: assert property (p_zero(body && hdr == 8'h23 && !cnt[0]))
		else $error("io gap bit set");
endmodule : sbc_flag_status_readout_chk
bind sbc_flag_status_readout sbc_flag_status_readout_chk chk (.CLK(CLK), .SRST(SRST), .SPI_SCLK(SPI_SCLK),
	.CHIP_SELECT_PIN_N(CHIP_SELECT_PIN_N), .SPI_MOSI(SPI_MOSI), .SPI_MISO(SPI_MISO), .SPI_MISO_OE(SPI_MISO_OE));
`default_nettype wire

// File: tb_sbc_flag_status_readout.sv
/* self-checking bench for the read-back block.
 assumes the host model frames every read. */
`timescale 1ns/1ps
`default_nettype none
module tb_sbc_flag_status_readout
	import sbc_readout_pkg::*;
;
	localparam logic [1:0] PC = 2'h2; // arbitrary value
	localparam logic [4:0] IC = 5'h15; // arbitrary value
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic sclk, cs_n, mosi, miso;
	flag_bytes_t ev = '0;
	live_in_t lv = '0;
	logic [15:0] r;
	int mismatches = 0;
	int num_checks = 0;
	logic [15:0] fc [7] = '{16'he100, 16'he180, 16'he300, 16'he380, 16'he500, 16'he580, 16'he700};
	logic [7:0] fm [7] = '{MASK_CAN_LO, MASK_CAN_HI, MASK_IO_LO, MASK_IO_HI, MASK_SAFE_LO, MASK_SAFE_HI, MASK_LIN_LO};
	always #2.5 clk = ~clk;
	sbc_flag_status_readout #(.PART_CODE(PC), .IDENT_CODE(IC)) dut (.CLK(clk), .SRST(srst), .SPI_SCLK(sclk),
		.CHIP_SELECT_PIN_N(cs_n), .SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_MISO_OE(), .FAULT_EVENT(ev), .LIVE_IN(lv));
	sbc_host_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic rd(input logic [15:0] cmd, input logic [7:0] e);
		host.frame(cmd, 16, r);
		num_checks++;
		if (r !== {8'h00, e})
		begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, r, {8'h00, e});
		end
	endtask : rd
	initial
	begin
		#100000;
		mismatches++;
		give_verdict();
	end
	initial
	begin
		step(8);
		srst = 1'b0;
		step(8);
		for (int k = 0; k < 2; k++)
		begin
			lv = k ? 10'h135 : 10'h2ca;
			step(8);
			rd(16'h2180, {lv.can_driver_on, lv.can_receiver_on, lv.can_wake_enable_state, 5'h00});
			rd(16'h2380, {1'b0, lv.io_level[3], 1'b0, lv.io_level[2], 1'b0, lv.io_level[1], 1'b0, lv.io_level[0]});
			rd(16'h2580, {lv.vdd_is_5v, PC, IC});
			rd(16'h2780, {lv.lin_transceiver_state, lv.lin_wake_enable_state, 6'h00});
		end
		host.frame(16'h2780, 17, r);
		$display("live test done");
		ev = '1;
		step(10);
		ev = '0;
		step(10);
		for (int k = 0; k < 2; k++)
			foreach (fc[j])
				rd(fc[j], k ? 8'h00 : fm[j]);
		rd(16'he780, 8'h00);
		$display("flag test done");
		ev.can_hi = 8'hff;
		step(10);
		rd(16'he180, 8'hff);
		rd(16'he180, 8'hff);
		ev = '0;
		step(10);
		rd(16'he080, 8'h00);
		rd(16'h6180, 8'h00);
		rd(16'he900, 8'h00);
		rd(16'he180, 8'hff);
		rd(16'he180, 8'h00);
		$display("clear test done");
		give_verdict();
	end
endmodule : tb_sbc_flag_status_readout
`default_nettype wire
